// ---- imst_consts.svh ----
// Register map, reset values, field positions and timing counts for the sample timing block
`ifndef IMST_CONSTS_SVH
`define IMST_CONSTS_SVH
`define IMST_ADDR_MISC     7'h60
`define IMST_ADDR_SCALE    7'h62
`define IMST_ADDR_DEC      7'h64
`define IMST_ADDR_BIAS     7'h66
`define IMST_ADDR_GCMD     7'h68
`define IMST_RST_MISC      8'hC1
`define IMST_RST_SCALE     16'h07D0
`define IMST_RST_DEC       11'h000
`define IMST_RST_BIAS      16'h070A
`define IMST_DEC_MAX       11'h7CF
`define IMST_TBE_MAX       4'hC
`define IMST_DEC_HI_BITS   3
`define IMST_BIT_BIASUPD   0
`define IMST_BIT_WRITE     15
`define IMST_FRAME_BITS    5'h10
`define IMST_CLK_HZ        10000000
`define IMST_ACC_RATE_HZ   4000
`define IMST_ACC_CYCLES    (`IMST_CLK_HZ / `IMST_ACC_RATE_HZ)
`define IMST_SYNC_PULSE_NS 10000
`define IMST_SYNC_PULSE_CYC ((`IMST_SYNC_PULSE_NS * (`IMST_CLK_HZ / 1000000)) / 1000)
`endif

// ---- imst_pkg.sv ----
// Types shared by the sample timing block
package imst_pkg;
   typedef enum logic [2:0] {
      IMST_INTERNAL = 3'h0,
      IMST_DIRECT   = 3'h1,
      IMST_SCALED   = 3'h2,
      IMST_OUTPUT   = 3'h3,
      IMST_RSV4     = 3'h4,
      IMST_PULSE    = 3'h5,
      IMST_RSV6     = 3'h6,
      IMST_RSV7     = 3'h7
   } imst_src_t;

   typedef enum logic [1:0] {
      SP_IDLE  = 2'h0,
      SP_SHIFT = 2'h1,
      SP_DONE  = 2'h3
   } imst_spi_t;

   typedef struct packed {
      logic      linComp;
      logic      percAlign;
      logic      zero5;
      imst_src_t src;
      logic      syncPol;
      logic      drPol;
   } imst_misc_t;

   typedef struct packed {
      logic [1:0] rsvdHi;
      logic [5:0] axisEn;
      logic [3:0] rsvdLo;
      logic [3:0] tbe;
   } imst_bias_t;

   typedef struct packed {
      logic linComp;
      logic percAlign;
      logic narrowBw;
      logic pairAvg;
   } imst_sens_t;
endpackage

// ---- imst_sync.sv ----
// Two-stage synchroniser for asynchronous pins
module imst_sync
   import imst_pkg::*;
#(
   parameter int W = 1
)
(
   // Clock, reset, enable
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic         ce,
   // Pins
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] pinSync_q
);
   logic [W-1:0] meta_q;

   generate
      if (W < 1)
      begin : g_chk
         $error("imst_sync width must be at least one");
      end
   endgenerate

   // First stage feeds only the second
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_q    <= '0;
         pinSync_q <= '0;
      end
      else if (ce)
      begin
         meta_q    <= pinIn;
         pinSync_q <= meta_q;
      end
   end
endmodule // imst_sync

// ---- imst_scale_gen.sv ----
// Scaled-mode tick generator: spreads scale ticks over each measured external period
module imst_scale_gen
   import imst_pkg::*;
#(
   parameter int CNT_W = 24
)
(
   // Clock, reset, enable
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   // Control
   input  wire logic        enable,
   input  wire logic        edgeAct,
   input  wire logic [15:0] scale,
   // Tick out
   output logic             tick_q
);
   logic [CNT_W-1:0] since_q;
   logic [CNT_W-1:0] period_q;
   logic [CNT_W-1:0] acc_q;
   logic [CNT_W:0]   sum;

   generate
      if (CNT_W < 17)
      begin : g_chk
         $error("imst_scale_gen counter must exceed the scale width");
      end
   endgenerate

   assign sum = {1'b0, acc_q} + {{(CNT_W - 15){1'b0}}, scale};

   // Period measurement between selected edges
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         since_q  <= '0;
         period_q <= '0;
      end
      else if (ce)
      begin
         if (!enable)
         begin
            since_q  <= '0;
            period_q <= '0;
         end
         else if (edgeAct)
         begin
            period_q <= CNT_W'(since_q + 1'b1);
            since_q  <= '0;
         end
         else if (since_q != '1)
         begin
            since_q <= CNT_W'(since_q + 1'b1);
         end
      end
   end

   // Accumulator spreads ticks, realigned at every edge
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         acc_q  <= '0;
         tick_q <= 1'b0;
      end
      else if (ce)
      begin
         tick_q <= 1'b0;
         if (!enable)
         begin
            acc_q <= '0;
         end
         else if (edgeAct)
         begin
            acc_q  <= '0;
            tick_q <= 1'b1;
         end
         else if (period_q != '0)
         begin
            if (sum >= {1'b0, period_q})
            begin
               acc_q  <= CNT_W'(sum - {1'b0, period_q});
               tick_q <= 1'b1;
            end
            else
            begin
               acc_q <= sum[CNT_W-1:0];
            end
         end
      end
   end
endmodule // imst_scale_gen

// ---- imst_timing.sv ----
// Sample timing, decimation, compensation and bias estimator configuration with serial access
// Behaviour
// - Percussion alignment bit, set by default, maps accelerometers to the package corner.
// - Control bit 7, set by default, enables linear-g compensation for gyroscopes.
// - Source code 000 runs sampling from the internal clock at 2000 Hz.
// - Internal mode averages two accelerometer samples taken at 4000 Hz per update.
// - Code 011 acts as internal mode and pulses the timing pin per sample.
// - Code 001: pin is sample clock; gyro on active edge, accel on both.
// - Device keeps working when the external clock runs slower than recommended.
// - Code 101 samples on leading edges only and narrows bandwidth to 370 Hz.
// - Code 010 makes an internal clock of pin frequency times scale factor.
// - Decimation count sits in bits 10:0, at most 1999, resets to zero.
// - Decimation applies to gyro and accel data and stretches delta intervals.
// - Internal mode output rate is 2000 over decimation count plus one.
// - Scaled rate uses scale factor; direct and pulse modes use factor one.
// - Bias config bits 13:8 enable per-axis correction, accel Z..X, gyro Z..X.
// - Time base exponent bits 3:0 accepts 0 to 12, default 10.
// - Bias configuration resets to 0x070A.
// - Estimator results are applied on the bias correction update command.
// - Timing polarity 1 selects rising edges, 0 falling, in and out.
// - Writing 1 to global command bit 0 applies estimator corrections.
`include "imst_consts.svh"
module imst_timing
   import imst_pkg::*;
#(
   parameter int SCALE_CNT_W = 24
)
(
   // Clock, reset, enable
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic ce,
   // Serial port
   input  wire logic spiSclk,
   input  wire logic spiCsB,
   input  wire logic spiDin,
   output logic      spiDout,
   // Timing pin
   input  wire logic syncIn,
   output logic      syncOut,
   output logic      syncOeB,
   // Sampling events
   output logic      gyroSample,
   output logic      accelSample,
   output logic      dataUpdate,
   output logic      dataReady,
   // Sensor and estimator control
   output imst_sens_t sensCtl,
   output logic [5:0] biasAxisEn,
   output logic [3:0] timeBaseExp,
   output logic       biasApply
);
   localparam int ACC_CYC   = `IMST_ACC_CYCLES;
   localparam int PULSE_CYC = `IMST_SYNC_PULSE_CYC;

   generate
      if (ACC_CYC < 2 || ACC_CYC > 4096 || PULSE_CYC < 1 || PULSE_CYC > 255)
      begin : g_chk
         $error("imst_timing timing counts out of range");
      end
   endgenerate

   // Same register word for either byte address
   function automatic logic hits(input logic [6:0] a, input logic [6:0] base);
      return a[6:1] == base[6:1];
   endfunction

   logic [3:0]  pinS;
   logic [2:0]  prev_q;
   logic        sclkRise, sclkFall, csFall, csRise;
   logic        syncRise, syncFall, syncAct, syncOther;
   imst_spi_t   spi_q;
   logic [4:0]  bitCnt_q;
   logic [15:0] rx_q, tx_q, readData_q, rdWord;
   logic        wrEn, rdEn;
   logic [6:0]  addr;
   logic [7:0]  wdat;
   imst_misc_t  misc_q;
   logic [15:0] scale_q;
   logic [10:0] dec_q, decNew, decCnt_q;
   imst_bias_t  bias_q;
   imst_src_t   mode;
   logic [11:0] accCnt_q;
   logic        phase_q, accTickI, scaleTick, tickG, tickA, upd;
   logic [7:0]  pulseCnt_q;

   // Pin synchronisation
   imst_sync #(.W(4)) uSync (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .ce        (ce),
      .pinIn     ({syncIn, spiDin, spiCsB, spiSclk}),
      .pinSync_q (pinS)
   );

   // Edge history
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         prev_q <= 3'h0;
      else if (ce)
         prev_q <= {pinS[3], pinS[1], pinS[0]};
   end

   assign sclkRise  = pinS[0] & ~prev_q[0];
   assign sclkFall  = ~pinS[0] & prev_q[0];
   assign csFall    = ~pinS[1] & prev_q[1];
   assign csRise    = pinS[1] & ~prev_q[1];
   assign syncRise  = pinS[3] & ~prev_q[2];
   assign syncFall  = ~pinS[3] & prev_q[2];
   assign syncAct   = misc_q.syncPol ? syncRise : syncFall;
   assign syncOther = misc_q.syncPol ? syncFall : syncRise;

   // Serial frame engine: shift in on rising clock, out on falling
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         spi_q    <= SP_IDLE;
         bitCnt_q <= 5'h00;
         rx_q     <= 16'h0000;
         tx_q     <= 16'h0000;
      end
      else if (ce)
      begin
         case (spi_q)
            SP_IDLE:
            begin
               if (csFall)
               begin
                  spi_q    <= SP_SHIFT;
                  bitCnt_q <= 5'h00;
                  tx_q     <= readData_q;
               end
            end
            SP_SHIFT:
            begin
               if (csRise)
                  spi_q <= (bitCnt_q == `IMST_FRAME_BITS) ? SP_DONE : SP_IDLE;
               else if (sclkRise && bitCnt_q != `IMST_FRAME_BITS)
               begin
                  rx_q     <= {rx_q[14:0], pinS[2]};
                  bitCnt_q <= 5'(bitCnt_q + 1'b1);
               end
               else if (sclkFall && bitCnt_q != 5'h00)
                  tx_q <= {tx_q[14:0], 1'b0}; // First fall precedes the first sample
            end
            default:
               spi_q <= SP_IDLE;
         endcase
      end
   end

   assign spiDout = tx_q[15];
   assign wrEn    = (spi_q == SP_DONE) && rx_q[`IMST_BIT_WRITE];
   assign rdEn    = (spi_q == SP_DONE) && !rx_q[`IMST_BIT_WRITE];
   assign addr    = rx_q[14:8];
   assign wdat    = rx_q[7:0];

   // Read decode
   always_comb
   begin
      rdWord = 16'h0000;
      if (hits(addr, `IMST_ADDR_MISC))
         rdWord = {8'h00, misc_q};
      else if (hits(addr, `IMST_ADDR_SCALE))
         rdWord = scale_q;
      else if (hits(addr, `IMST_ADDR_DEC))
         rdWord = {5'h00, dec_q};
      else if (hits(addr, `IMST_ADDR_BIAS))
         rdWord = bias_q;
   end

   // Read data returned in the next frame
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         readData_q <= 16'h0000;
      else if (ce && rdEn)
         readData_q <= rdWord;
   end

   // Miscellaneous control: compensation, source, polarities
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         misc_q <= `IMST_RST_MISC;
      else if (ce && wrEn && hits(addr, `IMST_ADDR_MISC) && !addr[0])
         misc_q <= {wdat[7:6], 1'b0, wdat[4:0]};
   end

   // Scale factor, one byte per command
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         scale_q <= `IMST_RST_SCALE;
      else if (ce && wrEn && hits(addr, `IMST_ADDR_SCALE))
      begin
         if (addr[0])
            scale_q[15:8] <= wdat;
         else
            scale_q[7:0] <= wdat;
      end
   end

   // Decimation count, clamped to its ceiling
   assign decNew = addr[0] ? {wdat[`IMST_DEC_HI_BITS-1:0], dec_q[7:0]} : {dec_q[10:8], wdat};
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         dec_q <= `IMST_RST_DEC;
      else if (ce && wrEn && hits(addr, `IMST_ADDR_DEC))
         dec_q <= (decNew > `IMST_DEC_MAX) ? `IMST_DEC_MAX : decNew;
   end

   // Bias estimator configuration
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         bias_q <= `IMST_RST_BIAS;
      else if (ce && wrEn && hits(addr, `IMST_ADDR_BIAS))
      begin
         if (addr[0])
            bias_q.axisEn <= wdat[5:0];
         else if (wdat[3:0] <= `IMST_TBE_MAX)
            bias_q.tbe <= wdat[3:0];
      end
   end

   // Bias correction update command
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         biasApply <= 1'b0;
      else if (ce)
         biasApply <= wrEn && hits(addr, `IMST_ADDR_GCMD) && !addr[0]
                      && wdat[`IMST_BIT_BIASUPD];
   end

   assign biasAxisEn  = bias_q.axisEn;
   assign timeBaseExp = bias_q.tbe;
   assign mode        = misc_q.src;

   // Internal 4000 Hz accelerometer clock, every second tick feeds the gyro
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         accCnt_q <= 12'h000;
         phase_q  <= 1'b0;
      end
      else if (ce)
      begin
         if (mode != IMST_INTERNAL && mode != IMST_OUTPUT)
         begin
            accCnt_q <= 12'h000;
            phase_q  <= 1'b0;
         end
         else if (accTickI)
         begin
            accCnt_q <= 12'h000;
            phase_q  <= ~phase_q;
         end
         else
            accCnt_q <= 12'(accCnt_q + 1'b1);
      end
   end
   assign accTickI = (accCnt_q == 12'(ACC_CYC - 1));

   // Scaled external clock
   imst_scale_gen #(.CNT_W(SCALE_CNT_W)) uScale (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .ce      (ce),
      .enable  (mode == IMST_SCALED),
      .edgeAct (syncAct),
      .scale   (scale_q),
      .tick_q  (scaleTick)
   );

   // Sample tick selection by timing source
   always_comb
   begin
      tickG = 1'b0;
      tickA = 1'b0;
      case (mode)
         IMST_INTERNAL, IMST_OUTPUT:
         begin
            tickA = accTickI;
            tickG = accTickI & phase_q;
         end
         IMST_DIRECT:
         begin
            tickG = syncAct;
            tickA = syncRise | syncFall;
         end
         IMST_PULSE:
         begin
            tickG = syncAct;
            tickA = syncAct;
         end
         IMST_SCALED:
         begin
            tickG = scaleTick;
            tickA = scaleTick;
         end
         default:
         begin
            tickG = 1'b0;
            tickA = 1'b0;
         end
      endcase
   end

   // Decimation of processed samples
   assign upd = tickG && (decCnt_q >= dec_q);
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         decCnt_q <= 11'h000;
      else if (ce && tickG)
         decCnt_q <= upd ? 11'h000 : 11'(decCnt_q + 1'b1);
   end

   // Sample and update strobes
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         gyroSample  <= 1'b0;
         accelSample <= 1'b0;
         dataUpdate  <= 1'b0;
         dataReady   <= 1'b0;
      end
      else if (ce)
      begin
         gyroSample  <= tickG;
         accelSample <= tickA;
         dataUpdate  <= upd;
         dataReady   <= misc_q.drPol ? upd : ~upd;
      end
   end

   // Output timing pulse per collected sample
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pulseCnt_q <= 8'h00;
         syncOut    <= 1'b1;
         syncOeB    <= 1'b1;
      end
      else if (ce)
      begin
         if (mode == IMST_OUTPUT && tickG)
            pulseCnt_q <= 8'(PULSE_CYC);
         else if (pulseCnt_q != 8'h00)
            pulseCnt_q <= 8'(pulseCnt_q - 1'b1);
         syncOut <= ((mode == IMST_OUTPUT && tickG) || pulseCnt_q > 8'h01)
                    ? misc_q.syncPol : ~misc_q.syncPol;
         syncOeB <= (mode != IMST_OUTPUT);
      end
   end

   // Sensor path controls
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         sensCtl <= 4'hD;
      else if (ce)
         sensCtl <= '{linComp: misc_q.linComp, percAlign: misc_q.percAlign,
                      narrowBw: (mode == IMST_PULSE),
                      pairAvg: (mode == IMST_INTERNAL || mode == IMST_OUTPUT
                                || mode == IMST_DIRECT)};
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_int_pair: assert property (ce && mode == IMST_INTERNAL && gyroSample |-> accelSample)
      else $error("gyro sample without accel sample in internal mode");
   a_int_spacing: assert property (ce && mode == IMST_INTERNAL && accelSample
                                   |=> !accelSample [*8])
      else $error("internal accel ticks too close");
   a_direct_both: assert property (ce && mode == IMST_DIRECT && (syncRise || syncFall)
                                   |=> accelSample)
      else $error("direct mode edge did not sample accel");
   a_pulse_lead: assert property (ce && mode == IMST_PULSE && syncOther |=> !accelSample)
      else $error("pulse mode sampled on trailing edge");
   a_sync_drive: assert property (ce && mode == IMST_OUTPUT && tickG ##1 ce
                                  |-> (syncOut == misc_q.syncPol) [*4])
      else $error("output timing pulse too short");
   a_oe_mode: assert property (!syncOeB |-> $past(misc_q.src) == IMST_OUTPUT)
      else $error("timing pin driven outside output mode");
   a_dec_ceil: assert property (dec_q <= `IMST_DEC_MAX)
      else $error("decimation count above ceiling");
   a_tbe_range: assert property (bias_q.tbe <= `IMST_TBE_MAX)
      else $error("time base exponent out of range");
   a_bias_cmd: assert property (ce && wrEn && addr == `IMST_ADDR_GCMD && wdat[0]
                                |=> biasApply)
      else $error("bias update command not applied");
   a_update_cause: assert property (dataUpdate |-> $past(tickG))
      else $error("data update without a processed sample");
   a_rsv_idle: assert property (ce && (mode == IMST_RSV4 || mode == IMST_RSV6
                                || mode == IMST_RSV7) |=> !gyroSample)
      else $error("sampling in reserved source");

   c_int_update: cover property (mode == IMST_INTERNAL && dataUpdate);
   c_direct_tick: cover property (mode == IMST_DIRECT && gyroSample);
   c_scaled_tick: cover property (mode == IMST_SCALED && gyroSample);
   c_bias_apply: cover property (biasApply);
endmodule // imst_timing

// ---- imst_host_model.sv ----
// Host model: serial master and driver of the external timing pin
module imst_host_model
(
   // Clock
   input  wire logic   mclk,
   // Serial port
   output logic        spiSclk,
   output logic        spiCsB,
   output logic        spiDin,
   input  wire logic   spiDout,
   // Timing pin drive
   output logic        syncDrv,
   // Word read back in the last frame
   output logic [15:0] rxWord,
   output logic        rxValid
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle levels: clock high, select high, timing pin low
   initial
   begin
      spiSclk = 1'b1;
      spiCsB  = 1'b1;
      spiDin  = 1'b0;
      syncDrv = 1'b0;
      rxWord  = 16'h0000;
      rxValid = 1'b0;
   end

   // One 16-bit frame, mode 3, five mclk per clock half; note flags a read result
   task automatic xfer(input logic [15:0] w, input logic note);
      logic [15:0] r;
      @(negedge mclk);
      spiCsB = 1'b0;
      repeat (5) @(negedge mclk);
      for (int i = 15; i >= 0; i--)
      begin
         spiSclk = 1'b0;
         spiDin  = w[i];
         repeat (5) @(negedge mclk);
         spiSclk = 1'b1;
         r[i]    = spiDout;
         repeat (5) @(negedge mclk);
      end
      spiCsB  = 1'b1;
      spiDin  = ~spiDin;   // Released line shows no stale value
      rxWord  = r;
      rxValid = note;
      @(negedge mclk);
      rxValid = 1'b0;
      repeat (10) @(negedge mclk);
   endtask

   // Sixteen-bit register load as two byte commands, low address first
   task automatic wr16(input logic [6:0] a, input logic [15:0] v);
      xfer({1'b1, a, v[7:0]}, 1'b0);
      xfer({1'b1, a | 7'h01, v[15:8]}, 1'b0);
   endtask

   // Pin clock: rising edge is the active one with polarity set
   task automatic pin_clk(input int n, input int hi, input int lo);
      repeat (n)
      begin
         syncDrv = 1'b1;
         repeat (hi) @(negedge mclk);
         syncDrv = 1'b0;
         repeat (lo) @(negedge mclk);
      end
   endtask
endmodule // imst_host_model

// ---- imst_timing_test.sv ----
// Self-checking bench for the sample timing block
module imst_timing_test
   import imst_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic        ce = 1'b1;
   logic        spiSclk, spiCsB, spiDin, spiDout;
   logic        syncDrv, syncWire, syncOut, syncOeB;
   logic        gyroSample, accelSample, dataUpdate, dataReady, biasApply, rxValid;
   imst_sens_t  sensCtl;
   logic [5:0]  biasAxisEn;
   logic [3:0]  timeBaseExp;
   logic [15:0] rxWord, sv;
   logic [15:0] expQ[$];
   int          num_errors = 0;
   int          total_checks = 0;
   int          cyc = 0;
   int          nGy, nAc, nUp, nRdy, nAp, nHi;

   // Wire level of the shared timing pin
   assign syncWire = syncOeB ? syncDrv : syncOut;

   always #50 mclk = ~mclk;

   imst_timing #(.SCALE_CNT_W(17)) imst_timing_i (.mclk(mclk), .rst_b(rst_b), .ce(ce),
      .spiSclk(spiSclk), .spiCsB(spiCsB), .spiDin(spiDin), .spiDout(spiDout),
      .syncIn(syncWire), .syncOut(syncOut), .syncOeB(syncOeB), .gyroSample(gyroSample),
      .accelSample(accelSample), .dataUpdate(dataUpdate), .dataReady(dataReady),
      .sensCtl(sensCtl), .biasAxisEn(biasAxisEn), .timeBaseExp(timeBaseExp),
      .biasApply(biasApply));

   imst_host_model imst_host_model_i (.mclk(mclk), .spiSclk(spiSclk), .spiCsB(spiCsB),
      .spiDin(spiDin), .spiDout(spiDout), .syncDrv(syncDrv), .rxWord(rxWord),
      .rxValid(rxValid));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Read: note the expected word, then fetch it in a second frame
   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      expQ.push_back(e);
      imst_host_model_i.xfer({1'b0, a, 8'h00}, 1'b0);
      imst_host_model_i.xfer(16'h0000, 1'b1);
   endtask

   task automatic clr();
      @(negedge mclk);
      {nGy, nAc, nUp, nRdy, nAp, nHi} = '0;
   endtask

   // Event counters and the hang limit
   always @(posedge mclk)
   begin
      cyc++;
      nGy  += int'(gyroSample === 1'b1);
      nAc  += int'(accelSample === 1'b1);
      nUp  += int'(dataUpdate === 1'b1);
      nRdy += int'(dataReady === 1'b1);
      nAp  += int'(biasApply === 1'b1);
      nHi  += int'(syncOut === 1'b1 && syncOeB === 1'b0);
      if (cyc == 100000)
      begin
         num_errors++;
         close_out();
      end
   end

   // Read results against the oldest note
   always @(posedge mclk)
   begin
      if (rxValid === 1'b1)
         chk(rxWord, (expQ.size() > 0) ? expQ.pop_front() : 16'hDEAD);
   end

   initial
   begin
      void'($urandom(65263));
      repeat (4) @(negedge mclk);
      rst_b = 1'b1;
      repeat (4) @(negedge mclk);
      chk({12'h000, sensCtl}, 16'h000D);
      chk({10'h000, biasAxisEn}, 16'h0007);
      chk({12'h000, timeBaseExp}, 16'h000A);
      rd(7'h60, 16'h00C1);
      rd(7'h62, 16'h07D0);
      rd(7'h64, 16'h0000);
      rd(7'h66, 16'h070A);
      rd(7'h40, 16'h0000);
      sv = 16'($urandom);
      imst_host_model_i.wr16(7'h62, sv);
      rd(7'h62, sv);
      imst_host_model_i.wr16(7'h64, 16'hFFFF);
      rd(7'h64, 16'h07CF);
      imst_host_model_i.wr16(7'h66, 16'h3F0D);
      rd(7'h66, 16'h3F0A);
      imst_host_model_i.wr16(7'h66, 16'h050C);
      chk({2'b00, biasAxisEn, 4'h0, timeBaseExp}, 16'h050C);
      clr();
      imst_host_model_i.wr16(7'h68, 16'h0001);
      chk(16'(nAp), 16'h0001);
      imst_host_model_i.wr16(7'h64, 16'h0000);
      // Direct mode, rising edge active, last period slower than recommended
      imst_host_model_i.xfer(16'hE087, 1'b0);
      clr();
      chk({12'h000, sensCtl}, 16'h0009);
      imst_host_model_i.pin_clk(2, 2500, 2500);
      imst_host_model_i.pin_clk(1, 3000, 3000);
      chk({nGy[3:0], nAc[3:0], nUp[3:0], nRdy[3:0]}, 16'h3633);
      // Pulse mode with narrow pulses
      imst_host_model_i.xfer(16'hE097, 1'b0);
      clr();
      chk({12'h000, sensCtl}, 16'h000A);
      imst_host_model_i.pin_clk(3, 20, 4980);
      chk({nGy[3:0], nAc[3:0], nUp[3:0], 4'h0}, 16'h3330);
      // Output mode: device drives the pin
      imst_host_model_i.xfer(16'hE08F, 1'b0);
      repeat (200) @(negedge mclk);
      clr();
      repeat (10000) @(negedge mclk);
      chk({nGy[3:0], nAc[3:0], 7'h00, syncOeB}, 16'h2400);
      chk(16'(nHi), 16'd200);
      // Internal mode with decimation count one
      imst_host_model_i.xfer(16'hE081, 1'b0);
      imst_host_model_i.wr16(7'h64, 16'h0001);
      repeat (100) @(negedge mclk);
      clr();
      repeat (20000) @(negedge mclk);
      chk({nGy[3:0], nAc[3:0], nUp[3:0], nRdy[3:0]}, 16'h4822);
      // Scaled mode: four ticks per measured pin period, counted over two periods
      imst_host_model_i.wr16(7'h62, 16'h0004);
      imst_host_model_i.xfer(16'hE08B, 1'b0);
      imst_host_model_i.pin_clk(1, 2000, 2000);
      imst_host_model_i.pin_clk(1, 2000, 1999);
      clr();
      imst_host_model_i.pin_clk(2, 2000, 2000);
      chk({nGy[3:0], nAc[3:0], nUp[3:0], nRdy[3:0]}, 16'h8844);
      repeat (20) @(negedge mclk);
      close_out();
   end
endmodule // imst_timing_test
